//--- hw/sadc_map.svh
// Register addresses, field positions, reset values and timing for the converter
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH
`define SADC_ADDR_RESULT_LO 16'hff08
`define SADC_ADDR_RESULT_HI 16'hff09
`define SADC_ADDR_HIGH_BYTE 16'hff0a
`define SADC_ADDR_PIN_DIR 16'hff22
`define SADC_ADDR_MODE 16'hff28
`define SADC_ADDR_CHANNEL 16'hff29
`define SADC_ADDR_PIN_CFG 16'hff2f
`define SADC_RST_PIN_DIR 8'hff
`define SADC_RST_MODE 8'h00
`define SADC_RST_CHANNEL 8'h00
`define SADC_RST_PIN_CFG 8'h00
`define SADC_RST_RESULT_WORD 16'h0000
`define SADC_RST_HIGH_BYTE 8'h00
`define SADC_PIN_DIR_FIXED 8'he0
`define SADC_MODE_RUN_BIT 7
`define SADC_MODE_TIME_HI 5
`define SADC_MODE_TIME_LO 1
`define SADC_MODE_CE_BIT 0
`define SADC_MODE_MASK 8'hbf
`define SADC_FIELD3_MASK 8'h07
`define SADC_CHAN_MAX 3'h4
`define SADC_PIN_CFG_MAX 3'h5
`define SADC_SAR_MSB_TRIAL 10'h200
`define SADC_RESULT_SHIFT 6
`define SADC_DIV_UNIT 4
`define SADC_SAMPLE_TICKS 8
`endif

//--- hw/sadc_pkg.sv
// Types shared by the converter sequencer modules
package sadc_pkg;
  typedef logic [15:0] sadc_addr_t;
  typedef logic [7:0] sadc_byte_t;
  typedef logic [9:0] sadc_code_t;
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_SAMPLE,
    SADC_CONVERT
  } sadc_state_t;
endpackage : sadc_pkg

//--- hw/sadc_cfg_if.sv
// Register values and write pulses passed from the register file to the sequencer
`timescale 1ns/1ps
interface sadc_cfg_if;
  import sadc_pkg::*;
  sadc_byte_t pin_dir;
  sadc_byte_t mode;
  sadc_byte_t channel;
  sadc_byte_t pin_cfg;
  logic wr_mode;
  logic wr_chan;
  logic wr_cfg;
  modport regs (output pin_dir, output mode, output channel, output pin_cfg,
                output wr_mode, output wr_chan, output wr_cfg);
  modport seq (input pin_dir, input mode, input channel, input pin_cfg,
               input wr_mode, input wr_chan, input wr_cfg);
endinterface : sadc_cfg_if

//--- hw/sadc_regfile.sv
// Writable configuration registers of the converter
`timescale 1ns/1ps
`include "sadc_map.svh"
module sadc_regfile (
  input wire logic core_clk,             // Core clock
  input wire logic rst_n,                // Async reset, active low
  input wire sadc_pkg::sadc_addr_t addr, // Register address
  input wire logic wr,                   // Write strobe
  input wire sadc_pkg::sadc_byte_t wdata, // Write data
  sadc_cfg_if.regs cfg                   // Values to the sequencer
);
  import sadc_pkg::*;
  sadc_byte_t dir_reg, dir_next, mode_reg, mode_next;
  sadc_byte_t chan_reg, chan_next, pcfg_reg, pcfg_next;
  logic wm_reg, wm_next, wc_reg, wc_next, wp_reg, wp_next;

  always_comb begin
    dir_next = dir_reg;
    mode_next = mode_reg;
    chan_next = chan_reg;
    pcfg_next = pcfg_reg;
    wm_next = wr && addr == `SADC_ADDR_MODE;
    wc_next = wr && addr == `SADC_ADDR_CHANNEL;
    wp_next = wr && addr == `SADC_ADDR_PIN_CFG;
    // upper direction bits held at one
    if (wr && addr == `SADC_ADDR_PIN_DIR) begin
      dir_next = wdata | `SADC_PIN_DIR_FIXED;
    end
    if (wm_next) begin
      mode_next = wdata & `SADC_MODE_MASK;
    end
    // only the three code bits are stored
    if (wc_next) begin
      chan_next = wdata & `SADC_FIELD3_MASK;
    end
    if (wp_next) begin
      pcfg_next = wdata & `SADC_FIELD3_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_reg <= `SADC_RST_PIN_DIR;
      mode_reg <= `SADC_RST_MODE;
      chan_reg <= `SADC_RST_CHANNEL;
      pcfg_reg <= `SADC_RST_PIN_CFG;
      wm_reg <= 1'b0;
      wc_reg <= 1'b0;
      wp_reg <= 1'b0;
    end else begin
      dir_reg <= dir_next;
      mode_reg <= mode_next;
      chan_reg <= chan_next;
      pcfg_reg <= pcfg_next;
      wm_reg <= wm_next;
      wc_reg <= wc_next;
      wp_reg <= wp_next;
    end
  end

  // Pulses line up with the cycle the new value is first visible
  assign cfg.pin_dir = dir_reg;
  assign cfg.mode = mode_reg;
  assign cfg.channel = chan_reg;
  assign cfg.pin_cfg = pcfg_reg;
  assign cfg.wr_mode = wm_reg;
  assign cfg.wr_chan = wc_reg;
  assign cfg.wr_cfg = wp_reg;
endmodule : sadc_regfile

//--- hw/sadc_tick.sv
// Step enable divider for sampling and bit trials
`timescale 1ns/1ps
module sadc_tick #(
  parameter int DIV_UNIT = 4,  // Core cycles per step per unit of the time field
  parameter int CNT_W = 12     // Counter width
) (
  input wire logic core_clk,       // Core clock
  input wire logic rst_n,          // Async reset, active low
  input wire logic clear,          // Restart the step period
  input wire logic [4:0] time_sel, // Conversion time field
  output logic tick                // One-cycle step enable
);
  logic [CNT_W-1:0] cnt_reg, cnt_next, last;

  generate
    if (DIV_UNIT < 4 || CNT_W < 8 || 32 * DIV_UNIT > 2 ** CNT_W) begin : g_bad
      $error("sadc_tick: step period must be 4+ cycles and fit the counter");
    end
  endgenerate

  // step period grows with the conversion time field
  assign last = CNT_W'((int'(time_sel) + 1) * DIV_UNIT - 1);
  assign tick = !clear && cnt_reg == last;

  always_comb begin
    cnt_next = cnt_reg + 1'b1;
    if (clear || cnt_reg == last) begin
      cnt_next = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : sadc_tick

//--- hw/sadc_seq.sv
// Successive-approximation converter sequencer with pin function decode
//
// Overview of operation
// - Direction register resets to all ones
// - Direction zero drives digital pin, one is input
// - Pin function from config, direction, channel
// - Comparator enable bit powers the comparator
// - Mode bits 5..1 select conversion time
// - Run bit starts converting selected channel
// - Sample fixed number of steps, then hold until done
// - First trial bit 9 at half reference
// - Bit 8 trial at quarter or three quarters
// - After ten bits latch results, raise done
// - Run bit held repeats conversions continuously
// - Channel write aborts and restarts conversion
// - Run bit cleared stops, result kept
// - Results reset to zero
// - Word result equals code times 64
// - High byte is upper eight code bits
// - Channel change to done equals conversion time
// - Channel codes 0..4 map to inputs
// - Pin config makes low pins digital
// - Word result low six bits zero
// - Config write at conversion end wins
`timescale 1ns/1ps
`include "sadc_map.svh"
module sadc_seq #(
  parameter int DIV_UNIT = `SADC_DIV_UNIT,       // Core cycles per step per time unit
  parameter int SAMPLE_TICKS = `SADC_SAMPLE_TICKS // Steps spent sampling
) (
  input wire logic core_clk,                  // Core clock, 200 MHz
  input wire logic rst_n,                     // Async reset, active low
  input wire sadc_pkg::sadc_addr_t cpu_addr,  // Register address
  input wire logic cpu_wr,                    // Write strobe
  input wire logic cpu_rd,                    // Read strobe
  input wire sadc_pkg::sadc_byte_t cpu_wdata, // Write data
  output sadc_pkg::sadc_byte_t cpu_rdata,     // Read data, one cycle after strobe
  input wire logic comp_above,                // Comparator: input at or above tap
  output sadc_pkg::sadc_code_t tap_code,      // Tap selector code (trial value)
  output logic comparator_power,              // Comparator powered
  output logic sample_switch,                 // Sampling switch closed
  output logic hold_active,                   // Sample-hold in hold
  output logic [2:0] analog_channel,          // Input routed to sample-hold
  output logic [4:0] pin_analog,              // Pin works as analog input
  output logic [4:0] pin_drive_en,            // Pin output buffer on
  output logic pin_setting_bad,               // Prohibited pin/channel setting
  output logic conversion_done_irq            // One-cycle conversion end request
);
  import sadc_pkg::*;

  sadc_cfg_if cfg ();

  sadc_regfile u_regs (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .addr(cpu_addr),
    .wr(cpu_wr),
    .wdata(cpu_wdata),
    .cfg(cfg)
  );

  logic run;
  logic tick;
  logic clear_div;
  logic [4:0] time_sel;

  assign run = cfg.mode[`SADC_MODE_RUN_BIT];
  // five-bit time field feeds the divider
  assign time_sel = cfg.mode[`SADC_MODE_TIME_HI:`SADC_MODE_TIME_LO];

  sadc_tick #(
    .DIV_UNIT(DIV_UNIT),
    .CNT_W(12)
  ) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(clear_div),
    .time_sel(time_sel),
    .tick(tick)
  );

  generate
    if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > 255) begin : g_bad
      $error("sadc_seq: SAMPLE_TICKS must be 1 to 255");
    end
  endgenerate

  // Comparator output is analog; synchronise before use
  logic comp_meta_reg, comp_sync_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      comp_meta_reg <= comp_above;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // Sequencer state
  sadc_state_t state_reg, state_next;
  sadc_code_t sar_reg, sar_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] samp_reg, samp_next;
  logic [15:0] word_reg, word_next;
  logic [7:0] high_reg, high_next;
  logic irq_reg, irq_next;
  logic cfg_write;
  logic restart;
  sadc_code_t trial;

  assign cfg_write = cfg.wr_mode || cfg.wr_chan || cfg.wr_cfg;
  // channel or mode write restarts from sampling
  assign restart = run && (cfg.wr_chan || cfg.wr_mode);
  assign clear_div = state_reg == SADC_IDLE || restart || !run;

  always_comb begin
    state_next = state_reg;
    sar_next = sar_reg;
    bit_next = bit_reg;
    samp_next = samp_reg;
    word_next = word_reg;
    high_next = high_reg;
    irq_next = 1'b0;
    // keep trial bit when input is above tap
    // the kept bit steers the next tap
    trial = sar_reg;
    if (!comp_sync_reg) begin
      trial = sar_reg & ~(10'h001 << bit_reg);
    end
    if (!run) begin
      state_next = SADC_IDLE;
      sar_next = '0;
      samp_next = '0;
    end else if (restart) begin
      state_next = SADC_SAMPLE;
      sar_next = '0;
      samp_next = '0;
    end else begin
      unique case (state_reg)
        SADC_IDLE: begin
          state_next = SADC_SAMPLE;
          samp_next = '0;
        end
        SADC_SAMPLE: begin
          if (tick) begin
            samp_next = samp_reg + 8'h01;
            if (samp_reg == 8'(SAMPLE_TICKS - 1)) begin
              state_next = SADC_CONVERT;
              sar_next = `SADC_SAR_MSB_TRIAL;
              bit_next = 4'h9;
            end
          end
        end
        SADC_CONVERT: begin
          if (tick) begin
            if (bit_reg == 4'h0) begin
              state_next = SADC_SAMPLE;
              samp_next = '0;
              sar_next = '0;
              if (!cfg_write) begin
                // latch both results and raise done
                word_next = {trial, 6'h00};
                // high byte is top eight code bits
                high_next = trial[9:2];
                irq_next = 1'b1;
              end
            end else begin
              bit_next = bit_reg - 4'h1;
              sar_next = trial | (10'h001 << (bit_reg - 4'h1));
            end
          end
        end
        default: begin
          state_next = SADC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SADC_IDLE;
      sar_reg <= '0;
      bit_reg <= 4'h0;
      samp_reg <= 8'h00;
      word_reg <= `SADC_RST_RESULT_WORD;
      high_reg <= `SADC_RST_HIGH_BYTE;
      irq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sar_reg <= sar_next;
      bit_reg <= bit_next;
      samp_reg <= samp_next;
      word_reg <= word_next;
      high_reg <= high_next;
      irq_reg <= irq_next;
    end
  end

  // Front-end controls registered: switches from next state, power and channel from registers
  logic samp_sw_reg, hold_reg, power_reg;
  logic [2:0] chan_out_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_sw_reg <= 1'b0;
      hold_reg <= 1'b0;
      power_reg <= 1'b0;
      chan_out_reg <= 3'h0;
    end else begin
      samp_sw_reg <= state_next == SADC_SAMPLE;
      hold_reg <= state_next == SADC_CONVERT;
      power_reg <= cfg.mode[`SADC_MODE_CE_BIT];
      chan_out_reg <= cfg.channel[2:0];
    end
  end

  // Pin function decode
  logic [4:0] is_digital, is_input, is_selected;
  logic [4:0] ana_next, drv_next;
  logic bad_next;
  logic [4:0] ana_reg, drv_reg;
  logic bad_reg;

  always_comb begin
    ana_next = '0;
    drv_next = '0;
    is_digital = '0;
    is_input = '0;
    is_selected = '0;
    for (int n = 0; n < 5; n++) begin
      // pins below the config value go digital
      is_digital[n] = 3'(n) < cfg.pin_cfg[2:0];
      is_input[n] = cfg.pin_dir[n];
      is_selected[n] = cfg.channel[2:0] == 3'(n);
      ana_next[n] = !is_digital[n] && is_input[n];
      // zero turns the output buffer on for digital pins
      drv_next[n] = is_digital[n] && !is_input[n];
    end
    bad_next = |(~is_digital & ~is_input) || |(is_digital & is_selected)
               || cfg.channel[2:0] > `SADC_CHAN_MAX
               || cfg.pin_cfg[2:0] > `SADC_PIN_CFG_MAX;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ana_reg <= 5'h00;
      drv_reg <= 5'h00;
      bad_reg <= 1'b0;
    end else begin
      ana_reg <= ana_next;
      drv_reg <= drv_next;
      bad_reg <= bad_next;
    end
  end

  // Register read port
  sadc_byte_t rdata_reg, rdata_next;
  always_comb begin
    rdata_next = 8'h00;
    if (cpu_rd) begin
      unique case (cpu_addr)
        // low six bits of word read zero
        `SADC_ADDR_RESULT_LO: rdata_next = word_reg[7:0];
        `SADC_ADDR_RESULT_HI: rdata_next = word_reg[15:8];
        `SADC_ADDR_HIGH_BYTE: rdata_next = high_reg;
        `SADC_ADDR_PIN_DIR: rdata_next = cfg.pin_dir;
        `SADC_ADDR_MODE: rdata_next = cfg.mode;
        `SADC_ADDR_CHANNEL: rdata_next = cfg.channel;
        `SADC_ADDR_PIN_CFG: rdata_next = cfg.pin_cfg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign cpu_rdata = rdata_reg;
  assign tap_code = sar_reg;
  assign comparator_power = power_reg;
  assign sample_switch = samp_sw_reg;
  assign hold_active = hold_reg;
  assign analog_channel = chan_out_reg;
  assign pin_analog = ana_reg;
  assign pin_drive_en = drv_reg;
  assign pin_setting_bad = bad_reg;
  assign conversion_done_irq = irq_reg;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_dir_upper_ones: assert property (cfg.pin_dir[7:5] == 3'b111)
    else $error("direction upper bits not one");
  a_drive_follows_dir: assert property ((pin_drive_en & $past(cfg.pin_dir[4:0])) == 5'h00)
    else $error("pin drive does not follow direction");
  a_analog_no_drive: assert property ((pin_analog & pin_drive_en) == 5'h00)
    else $error("analog pin with output buffer on");
  a_comp_power: assert property ($rose(cfg.mode[0]) |=> comparator_power)
    else $error("comparator not powered");
  a_start_sample: assert property ($rose(run) |=> ##[0:1] sample_switch)
    else $error("run did not start sampling");
  a_hold_convert: assert property (hold_active |-> !sample_switch)
    else $error("sampling while holding");
  a_first_trial: assert property ($rose(hold_active) |-> tap_code == 10'h200)
    else $error("first trial not at half scale");
  a_result_layout: assert property ($rose(irq_reg) |-> word_reg[5:0] == 6'h00
    && word_reg[15:8] == high_reg)
    else $error("result layout wrong");
  a_stop_keeps: assert property (!run |=> $stable(word_reg) && !irq_reg)
    else $error("result changed while stopped");
  a_chan_restart: assert property (cfg.wr_chan && run |=> sample_switch
    ##1 sample_switch)
    else $error("channel write did not restart");
  a_write_wins: assert property (cfg_write |=> !conversion_done_irq)
    else $error("done raised on config write");
  a_irq_pulse: assert property (conversion_done_irq |=> !conversion_done_irq)
    else $error("done not a single pulse");
  a_stop_switches: assert property (!run |=> !sample_switch && !hold_active)
    else $error("front end active while stopped");
  a_hold_order: assert property ($rose(hold_active) |-> $past(sample_switch))
    else $error("hold without sampling first");

  c_done: cover property (conversion_done_irq);
  c_two_done: cover property (conversion_done_irq ##[1:1000] conversion_done_irq);
  c_restart: cover property (hold_active && cfg.wr_chan);
  c_stop_mid: cover property (hold_active ##1 !run);
endmodule : sadc_seq

//--- bench/sadc_comp_model.sv
// Behavioural analog front end: input sources, sample-hold and comparator
`timescale 1ns/1ps
module sadc_comp_model (
  input wire logic core_clk,          // Core clock
  input wire logic powered,           // Comparator powered
  input wire logic sampling,          // Sampling switch closed
  input wire logic holding,           // Sample-hold in hold
  input wire logic [2:0] channel,     // Input routed to sample-hold
  input wire logic [9:0] tap,         // Tap selector code
  input wire logic [49:0] vin_codes,  // Input levels as ideal codes, input 0 lowest
  output logic above                  // Held input at or above tap
);
  logic [9:0] held_reg;
  logic toggle_reg = 1'b0;

  always @(posedge core_clk) begin
    toggle_reg <= ~toggle_reg;
    if (sampling && !holding) begin
      held_reg <= vin_codes[channel * 10 +: 10];
    end
  end

  // keep at or above
  // Unpowered comparator gives noise, never a stale answer
  assign above = powered ? (held_reg >= tap) : toggle_reg;
endmodule : sadc_comp_model

//--- bench/sar_adc_sequencer_tb_top.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "sadc_map.svh"
module sar_adc_sequencer_tb_top;
  import sadc_pkg::*;
  localparam int SAMPLE_TICKS = 2;
  // Time field left at 0, so one step is DIV_UNIT cycles
  localparam int STEP = 4;
  localparam int CONV = (SAMPLE_TICKS + 10) * STEP;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  sadc_addr_t cpu_addr = 16'h0000;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  sadc_byte_t cpu_wdata = 8'h00;
  sadc_byte_t cpu_rdata;
  sadc_code_t tap_code;
  logic comp_above;
  logic comparator_power;
  logic sample_switch;
  logic hold_active;
  logic pin_setting_bad;
  logic conversion_done_irq;
  logic [2:0] analog_channel;
  logic [4:0] pin_analog;
  logic [4:0] pin_drive_en;
  logic [49:0] vin_codes = {10'h155, 10'h1ff, 10'h200, 10'h3ff, 10'h000};
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int done_at = 0;

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  sadc_seq #(.DIV_UNIT(STEP), .SAMPLE_TICKS(SAMPLE_TICKS)) i_sadc_seq (
    .core_clk(core_clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .comp_above(comp_above), .tap_code(tap_code), .comparator_power(comparator_power),
    .sample_switch(sample_switch), .hold_active(hold_active),
    .analog_channel(analog_channel), .pin_analog(pin_analog), .pin_drive_en(pin_drive_en),
    .pin_setting_bad(pin_setting_bad), .conversion_done_irq(conversion_done_irq));

  sadc_comp_model i_sadc_comp_model (
    .core_clk(core_clk), .powered(comparator_power), .sampling(sample_switch),
    .holding(hold_active), .channel(analog_channel), .tap(tap_code),
    .vin_codes(vin_codes), .above(comp_above));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic bus_wr(input sadc_addr_t a, input sadc_byte_t d);
    @(posedge core_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge core_clk);
    cpu_wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input sadc_addr_t a, output sadc_byte_t d);
    @(posedge core_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge core_clk);
    cpu_rd <= 1'b0;
    #1 d = cpu_rdata;
  endtask : bus_rd

  task automatic wait_done(input int limit);
    for (int i = 0; i < limit; i++) begin
      @(posedge core_clk);
      #1;
      if (conversion_done_irq === 1'b1) begin
        done_at = cyc;
        return;
      end
    end
    miscompares++;
    $display("ERROR conversion end expected 1 seen 0");
    tally_and_finish();
  endtask : wait_done

  task automatic check_reg(input string what, input sadc_addr_t a, input sadc_byte_t exp);
    sadc_byte_t d;
    bus_rd(a, d);
    check(what, {8'h00, d}, {8'h00, exp});
  endtask : check_reg

  task automatic check_results(input sadc_code_t code);
    check_reg("result low byte", `SADC_ADDR_RESULT_LO, {code[1:0], 6'h00});
    check_reg("result high byte", `SADC_ADDR_RESULT_HI, code[9:2]);
    check_reg("short result", `SADC_ADDR_HIGH_BYTE, code[9:2]);
  endtask : check_results

  task automatic t_reset();
    check_reg("pin direction", `SADC_ADDR_PIN_DIR, 8'hff);
    check_reg("mode", `SADC_ADDR_MODE, 8'h00);
    check_reg("channel", `SADC_ADDR_CHANNEL, 8'h00);
    check_reg("pin config", `SADC_ADDR_PIN_CFG, 8'h00);
    check_reg("unmapped", 16'hff30, 8'h00);
    check_results(10'h000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_pins();
    bus_wr(`SADC_ADDR_PIN_DIR, 8'h00);
    bus_wr(`SADC_ADDR_PIN_CFG, 8'h05);
    check_reg("pin direction fixed", `SADC_ADDR_PIN_DIR, 8'he0);
    check("drive all", {11'h0, pin_drive_en, pin_setting_bad}, 16'h003f);
    check("analog none", {11'h0, pin_analog}, 16'h0000);
    bus_wr(`SADC_ADDR_PIN_CFG, 8'h02);
    bus_wr(`SADC_ADDR_PIN_DIR, 8'h1c);
    bus_wr(`SADC_ADDR_CHANNEL, 8'h02);
    repeat (2) @(posedge core_clk);
    #1 check("mixed pins", {pin_analog, pin_drive_en, pin_setting_bad}, 16'h0706);
    bus_wr(`SADC_ADDR_PIN_DIR, 8'h18);
    repeat (2) @(posedge core_clk);
    #1 check("analog output", {11'h0, pin_analog, pin_setting_bad}, 16'h0031);
    bus_wr(`SADC_ADDR_PIN_DIR, 8'hff);
    bus_wr(`SADC_ADDR_PIN_CFG, 8'h00);
    bus_wr(`SADC_ADDR_CHANNEL, 8'h00);
    repeat (2) @(posedge core_clk);
    #1 check("all analog", {pin_analog, pin_drive_en, pin_setting_bad}, 16'h07c0);
    $display("test pins done");
  endtask : t_pins

  task automatic t_convert();
    int start;
    int n;
    bus_wr(`SADC_ADDR_MODE, 8'h01);
    repeat (2) @(posedge core_clk);
    #1 check("comparator power", {15'h0, comparator_power}, 16'h0001);
    repeat (200) @(posedge core_clk);
    bus_wr(`SADC_ADDR_MODE, 8'h81);
    repeat (2) @(posedge core_clk);
    #1 check("sampling", {15'h0, sample_switch}, 16'h0001);
    wait_done(200);
    check_results(vin_codes[9:0]);
    for (int ch = 1; ch < 5; ch++) begin
      bus_wr(`SADC_ADDR_CHANNEL, 8'(ch));
      #1 start = cyc;
      repeat ((SAMPLE_TICKS + 1) * STEP + 2) @(posedge core_clk);
      #1 check("holding", {14'h0, hold_active, sample_switch}, 16'h0002);
      check("routed channel", {13'h0, analog_channel}, 16'(ch));
      wait_done(200);
      n = done_at - start;
      check("conversion time", 16'(n >= CONV - 1 && n <= CONV + 3), 16'h0001);
      check_results(vin_codes[ch * 10 +: 10]);
    end
    start = done_at;
    wait_done(200);
    n = done_at - start;
    check("repeat period", 16'(n >= CONV - 1 && n <= CONV + 3), 16'h0001);
    check_results(vin_codes[49:40]);
    $display("test convert done");
  endtask : t_convert

  task automatic t_collide();
    int pulses = 0;
    wait_done(200);
    // Conversion whose final step meets the write is dropped; the old result is kept
    @(posedge core_clk);
    vin_codes[49:40] <= 10'h0aa;
    repeat (44) @(posedge core_clk);
    bus_wr(`SADC_ADDR_PIN_CFG, 8'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      #1 if (conversion_done_irq === 1'b1) pulses++;
    end
    check("end under write", 16'(pulses), 16'h0000);
    check_results(10'h155);
    wait_done(200);
    check_results(10'h0aa);
    $display("test collide done");
  endtask : t_collide

  task automatic t_slow();
    int start;
    int n;
    // Time field of 1 doubles every step
    bus_wr(`SADC_ADDR_MODE, 8'h83);
    #1 start = cyc;
    wait_done(200);
    n = done_at - start;
    check("slow conversion time", 16'(n >= 2 * CONV - 1 && n <= 2 * CONV + 3), 16'h0001);
    check_results(vin_codes[49:40]);
    $display("test slow done");
  endtask : t_slow

  task automatic t_stop();
    int pulses = 0;
    repeat (20) @(posedge core_clk);
    bus_wr(`SADC_ADDR_MODE, 8'h01);
    for (int i = 0; i < 3 * CONV; i++) begin
      @(posedge core_clk);
      #1 if (conversion_done_irq === 1'b1) pulses++;
    end
    check("ends after stop", 16'(pulses), 16'h0000);
    check("switches after stop", {14'h0, hold_active, sample_switch}, 16'h0000);
    check_results(vin_codes[49:40]);
    $display("test stop done");
  endtask : t_stop

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_pins();
    t_convert();
    t_collide();
    t_stop();
    t_slow();
    tally_and_finish();
  end
endmodule : sar_adc_sequencer_tb_top
